// ### src/dcef_pkg.sv
// constants, field layouts and carriers shared by the elastic input buffer
package dcef_pkg;
  localparam int          DCEF_DEPTH     = 8;
  localparam int          DCEF_AW        = 3;
  localparam int          DCEF_SW        = 32;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_OFFS      = 8'h04;
  localparam logic [7:0]  ADDR_SEL       = 8'h08;
  localparam logic [7:0]  ADDR_STAT      = 8'h0c;
  localparam logic [7:0]  ADDR_SAMPLE    = 8'h10;
  // field positions
  localparam int          CTRL_ENA_BIT   = 0;
  localparam int          CTRL_WIDE_BIT  = 1;
  localparam int          CTRL_SIF_BIT   = 2;
  localparam int          CTRL_INTP_LSB  = 8;
  localparam int          SEL_OUT_LSB    = 4;
  localparam int          SEL_SIF        = 3;
  localparam int          SEL_OUTPUT_PHASE_STROBE       = 2;
  localparam int          SEL_FRAME      = 1;
  localparam int          SEL_SYNC       = 0;
  localparam int          STAT_RPTR_LSB  = 4;
  localparam int          STAT_ENA_BIT   = 8;
  // values after reset
  localparam logic        RST_ENA        = 1'b1;
  localparam logic        RST_WIDE       = 1'b1;
  localparam logic [4:0]  RST_INTERP     = 5'h02;
  localparam logic [2:0]  RST_OFFSET     = 3'h4;
  localparam logic [2:0]  RST_WPTR       = 3'h0;
  localparam logic [3:0]  RST_SEL_IN     = 4'h2;
  localparam logic [3:0]  RST_SEL_OUT    = 4'h4;
  // words per sample minus one
  localparam logic [1:0]  LAST_WORD_WIDE = 2'h1;
  localparam logic [1:0]  LAST_WORD_BYTE = 2'h3;

  typedef struct packed {
    logic       ena;
    logic       wide;
    logic [4:0] interp;
  } dcef_ctrl_t;

  typedef struct packed {
    logic        dclk;
    logic [15:0] data;
    logic        frame;
    logic        sync;
    logic        cclk;
    logic        output_phase_strobe;
  } dcef_pins_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } dcef_sample_t;
endpackage

// ### src/dcef_mem.sv
// eight-word sample store with registered read data
`timescale 1ns/1ps
module dcef_mem
  import dcef_pkg::*;
(
  input  wire logic                clk,    // system clock
  input  wire logic                rst_n,  // async reset, active low
  input  wire logic                we,     // write strobe
  input  wire logic [DCEF_AW-1:0]  waddr,  // write location
  input  wire logic [DCEF_SW-1:0]  wdata,  // write sample
  input  wire logic                re,     // read strobe
  input  wire logic [DCEF_AW-1:0]  raddr,  // read location
  output logic      [DCEF_SW-1:0]  q_ff    // registered read sample
);
  logic [DCEF_SW-1:0] mem [DCEF_DEPTH];
  logic [DCEF_SW-1:0] nxt_q;

  always_comb begin
    nxt_q = re ? mem[raddr] : q_ff;
  end

  // storage cleared on reset so reads ahead of the first lap stay defined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DCEF_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

// ### src/dcef_top.sv
// dual channel elastic input buffer with apb control registers
// Contract
// RQ1: eight-location buffer holding two 16-bit channels per sample.
// RQ2: data taken on both source clock edges, assembled 32-bit sample stored.
// RQ3: each output tick fetches one whole sample at the read pointer.
// RQ4: output tick divides converter clock by 2*interp (word) or interp.
// RQ5: both pointers step after each access, wrapping over eight locations.
// RQ6: pointer reset puts write at 0, read at 4 by default.
// RQ7: three-bit software offset sets read reset location, default 4.
// RQ8: system keeps write and read rates equal.
// RQ9: four-bit field selects the write pointer reset source.
// RQ10: write-side sync sampled on rising source clock edges only.
// RQ11: rising edge of selected sync returns pointer to reset location.
// RQ12: separate read select; write sync recaptured on output side.
// RQ13: read reset event also restarts the output clock divider.
// RQ14: phase strobe, sampled on converter clock, resets read pointer alone.
// RQ15: pointers wrap by themselves; one reset suffices, repeats allowed.
// RQ16: periodic syncs repeat at multiples of 8 or 16 samples.
// RQ17: frame or sync repeat no faster than source clock over 16n.
// RQ18: phase strobe repeat no faster than converter over n*interp*8/16.
// RQ19: buffer disabled means bypass, read select ignored.
// RQ20: read select bits: 3 serial, 2 strobe, 1 frame, 0 sync.
// RQ21: dual-sync: write from frame/sync, read from phase strobe.
// RQ22: byte format uses sync rising edge to set sample boundaries.
// RQ23: write sync passes a multi-stage recapture with edge detect.
`timescale 1ns/1ps
module dcef_top
  import dcef_pkg::*;
(
  input  wire logic         clk,          // 50 MHz system clock
  input  wire logic         rst_n,        // async reset, active low
  input  wire logic         psel,         // apb select
  input  wire logic         penable,      // apb access phase
  input  wire logic         pwrite,       // apb direction
  input  wire logic [7:0]   paddr,        // apb byte address
  input  wire logic [31:0]  pwdata,       // apb write data
  output logic              pready_ff,    // apb ready
  output logic      [31:0]  prdata_ff,    // apb read data
  output logic              pslverr_ff,   // apb unmapped address
  input  wire dcef_pins_t   pins,         // asynchronous input pins
  output dcef_sample_t      sample_ff,    // sample delivered to converter
  output logic              valid_ff,     // one-cycle sample strobe
  output logic              tick_ff       // buffer output clock tick
);
  function automatic logic pick(input logic [3:0] sel, input logic fr,
                                input logic sy, input logic os);
    pick = |(sel[2:0] & {os, fr, sy});
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // pin synchronisers; stage one is read only by stage two
  dcef_pins_t p1_ff, p2_ff, p3_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_ff <= '0;
      p2_ff <= '0;
      p3_ff <= '0;
    end else begin
      p1_ff <= pins;
      p2_ff <= p1_ff;
      p3_ff <= p2_ff;
    end
  end
  logic dclk_rise, dclk_fall, cclk_rise;
  assign dclk_rise = p2_ff.dclk & ~p3_ff.dclk;
  assign dclk_fall = ~p2_ff.dclk & p3_ff.dclk;
  assign cclk_rise = p2_ff.cclk & ~p3_ff.cclk;

  // register file
  dcef_ctrl_t   ctrl_ff, nxt_ctrl;
  logic [2:0]   offs_ff, nxt_offs;
  logic [7:0]   sel_ff, nxt_sel;
  logic         sif_ff, nxt_sif;
  logic [31:0]  nxt_prdata;
  logic         nxt_pready, nxt_pslverr, wr_acc, mapped;
  logic [2:0]   wptr_ff, rptr_ff;
  logic [3:0]   sel_in, sel_out;
  assign sel_in  = sel_ff[3:0];
  assign sel_out = sel_ff[SEL_OUT_LSB +: 4];
  assign wr_acc  = psel & penable & pready_ff & pwrite;
  assign mapped  = hit(paddr, ADDR_CTRL) | hit(paddr, ADDR_OFFS) |
                   hit(paddr, ADDR_SEL) | hit(paddr, ADDR_STAT) |
                   hit(paddr, ADDR_SAMPLE);

  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_offs    = offs_ff;
    nxt_sel     = sel_ff;
    nxt_sif     = 1'b0;
    nxt_pready  = psel & ~penable;
    nxt_pslverr = psel & ~penable & ~mapped;
    nxt_prdata  = prdata_ff;
    if (wr_acc && hit(paddr, ADDR_CTRL)) begin
      nxt_ctrl.ena    = pwdata[CTRL_ENA_BIT];
      nxt_ctrl.wide   = pwdata[CTRL_WIDE_BIT];
      nxt_ctrl.interp = pwdata[CTRL_INTP_LSB +: 5];
      nxt_sif         = pwdata[CTRL_SIF_BIT];
    end
    if (wr_acc && hit(paddr, ADDR_OFFS)) begin
      nxt_offs = pwdata[2:0]; // [RQ7]
    end
    if (wr_acc && hit(paddr, ADDR_SEL)) begin
      nxt_sel = pwdata[7:0]; // [RQ9] [RQ12]
    end
    if (psel && !penable) begin
      nxt_prdata = 32'h0000_0000;
      if (hit(paddr, ADDR_CTRL)) begin
        nxt_prdata[CTRL_ENA_BIT]        = ctrl_ff.ena;
        nxt_prdata[CTRL_WIDE_BIT]       = ctrl_ff.wide;
        nxt_prdata[CTRL_INTP_LSB +: 5]  = ctrl_ff.interp;
      end
      if (hit(paddr, ADDR_OFFS)) begin
        nxt_prdata[2:0] = offs_ff;
      end
      if (hit(paddr, ADDR_SEL)) begin
        nxt_prdata[7:0] = sel_ff;
      end
      if (hit(paddr, ADDR_STAT)) begin
        nxt_prdata[2:0]                 = wptr_ff;
        nxt_prdata[STAT_RPTR_LSB +: 3]  = rptr_ff;
        nxt_prdata[STAT_ENA_BIT]        = ctrl_ff.ena;
      end
      if (hit(paddr, ADDR_SAMPLE)) begin
        nxt_prdata = sample_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff    <= '{ena: RST_ENA, wide: RST_WIDE, interp: RST_INTERP};
      offs_ff    <= RST_OFFSET; // [RQ6]
      sel_ff     <= {RST_SEL_OUT, RST_SEL_IN};
      sif_ff     <= 1'b0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      offs_ff    <= nxt_offs;
      sel_ff     <= nxt_sel;
      sif_ff     <= nxt_sif;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // write side: assemble words or bytes into samples
  logic         wsmp_ff, nxt_wsmp, wsync_ev, edge_ev, done;
  logic [1:0]   phase_ff, nxt_phase, ph, last;
  logic [31:0]  asm_ff, nxt_asm, byp_ff, nxt_byp;
  logic         wr_en_ff, nxt_wr_en;
  logic [2:0]   wr_addr_ff, nxt_wr_addr, nxt_wptr, wuse;
  assign edge_ev  = dclk_rise | dclk_fall; // [RQ2]
  assign last     = ctrl_ff.wide ? LAST_WORD_WIDE : LAST_WORD_BYTE;
  assign nxt_wsmp = dclk_rise ? pick(sel_in, p2_ff.frame, p2_ff.sync, 1'b0)
                              : wsmp_ff; // [RQ10]
  assign wsync_ev = (dclk_rise & nxt_wsmp & ~wsmp_ff) |
                    (sif_ff & sel_in[SEL_SIF]); // [RQ11] [RQ9]

  always_comb begin
    ph          = wsync_ev ? 2'h0 : phase_ff; // [RQ22]
    wuse        = wsync_ev ? RST_WPTR : wptr_ff; // [RQ6]
    nxt_phase   = ph;
    nxt_asm     = asm_ff;
    nxt_wptr    = wuse;
    nxt_byp     = byp_ff;
    nxt_wr_en   = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    done        = 1'b0;
    if (edge_ev) begin
      nxt_asm = ctrl_ff.wide ? {asm_ff[15:0], p2_ff.data}
                             : {asm_ff[23:0], p2_ff.data[7:0]};
      done    = (ph == last);
      nxt_phase = done ? 2'h0 : ph + 2'h1;
    end
    if (done) begin
      nxt_wr_en   = 1'b1; // [RQ2]
      nxt_wr_addr = wuse;
      nxt_wptr    = wuse + 3'h1; // [RQ5] [RQ15]
      nxt_byp     = nxt_asm;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wsmp_ff    <= 1'b0;
      phase_ff   <= 2'h0;
      asm_ff     <= 32'h0000_0000;
      byp_ff     <= 32'h0000_0000;
      wr_en_ff   <= 1'b0;
      wr_addr_ff <= RST_WPTR;
      wptr_ff    <= RST_WPTR;
    end else begin
      wsmp_ff    <= nxt_wsmp;
      phase_ff   <= nxt_phase;
      asm_ff     <= nxt_asm;
      byp_ff     <= nxt_byp;
      wr_en_ff   <= nxt_wr_en;
      wr_addr_ff <= nxt_wr_addr;
      wptr_ff    <= nxt_wptr;
    end
  end

  // read side: divider, recapture of write sync, pointer
  logic         pend_ff, nxt_pend, output_phase_strobe_ff, nxt_output_phase_strobe, output_phase_strobe_ev, recap_ev;
  logic [2:0]   cap_ff, nxt_cap, nxt_rptr;
  logic [5:0]   div, divcnt_ff, nxt_divcnt;
  logic         rd_rst, tick, nxt_valid;
  logic [31:0]  mem_q;
  dcef_sample_t nxt_sample;
  // set wins over the clear taken by a converter edge
  assign nxt_pend = wsync_ev | (pend_ff & ~cclk_rise);
  assign nxt_cap  = cclk_rise ? {cap_ff[1:0], pend_ff} : cap_ff; // [RQ23]
  assign recap_ev = cclk_rise & cap_ff[1] & ~cap_ff[2]; // [RQ12] [RQ23]
  assign nxt_output_phase_strobe = cclk_rise ? p2_ff.output_phase_strobe : output_phase_strobe_ff;
  assign output_phase_strobe_ev  = cclk_rise & p2_ff.output_phase_strobe & ~output_phase_strobe_ff; // [RQ14]
  // read select only matters with the buffer in use
  assign rd_rst   = ctrl_ff.ena & ((sel_out[SEL_OUTPUT_PHASE_STROBE] & output_phase_strobe_ev) |
                    ((sel_out[SEL_FRAME] | sel_out[SEL_SYNC]) & recap_ev) |
                    (sel_out[SEL_SIF] & sif_ff)); // [RQ19] [RQ20] [RQ21]
  // zero interpolation gives a divide by one in either format to keep the divider alive
  assign div = (ctrl_ff.interp == 5'h00) ? 6'h01 :
               ctrl_ff.wide ? {ctrl_ff.interp, 1'b0}
                            : {1'b0, ctrl_ff.interp}; // [RQ4]
  assign tick = ~rd_rst & cclk_rise & (divcnt_ff >= div - 6'h01);

  always_comb begin
    nxt_divcnt = divcnt_ff;
    nxt_rptr   = rptr_ff;
    if (rd_rst) begin
      nxt_divcnt = 6'h00; // [RQ13]
      nxt_rptr   = offs_ff; // [RQ7] [RQ11]
    end else if (tick) begin
      nxt_divcnt = 6'h00;
      nxt_rptr   = rptr_ff + 3'h1; // [RQ5] [RQ15]
    end else if (cclk_rise) begin
      nxt_divcnt = divcnt_ff + 6'h01;
    end
    nxt_valid  = tick_ff;
    nxt_sample = sample_ff;
    if (tick_ff) begin
      nxt_sample = ctrl_ff.ena ? mem_q : byp_ff; // [RQ3] [RQ19]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff   <= 1'b0;
      cap_ff    <= 3'h0;
      output_phase_strobe_ff   <= 1'b0;
      divcnt_ff <= 6'h00;
      rptr_ff   <= RST_OFFSET; // [RQ6]
      tick_ff   <= 1'b0;
      valid_ff  <= 1'b0;
      sample_ff <= '0;
    end else begin
      pend_ff   <= nxt_pend;
      cap_ff    <= nxt_cap;
      output_phase_strobe_ff   <= nxt_output_phase_strobe;
      divcnt_ff <= nxt_divcnt;
      rptr_ff   <= nxt_rptr;
      tick_ff   <= tick;
      valid_ff  <= nxt_valid;
      sample_ff <= nxt_sample;
    end
  end

  dcef_mem u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (wr_en_ff),
    .waddr (wr_addr_ff),
    .wdata (asm_ff),
    .re    (tick),
    .raddr (rptr_ff),
    .q_ff  (mem_q)
  ); // [RQ1]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_WPTR_STEP: assert property (wr_en_ff |-> wptr_ff == wr_addr_ff + 3'h1)
    else $error("write pointer did not step after write"); // [RQ5]
  AST_RPTR_STEP: assert property (tick |=> rptr_ff == $past(rptr_ff) + 3'h1)
    else $error("read pointer did not step after read"); // [RQ5]
  AST_RD_RESET: assert property (rd_rst |=> rptr_ff == $past(offs_ff)
                                 && divcnt_ff == 6'h00 && !tick_ff)
    else $error("read reset missed offset or divider"); // [RQ7] [RQ13]
  // the word taken at the sync edge itself is word 0, so phase moves to 1
  AST_WR_RESET: assert property (wsync_ev && !done |=> wptr_ff == RST_WPTR
                                 && phase_ff == {1'b0, $past(edge_ev)})
    else $error("write sync did not reset write side"); // [RQ11]
  AST_WSYNC_EDGE: assert property (wsync_ev && !sif_ff |-> dclk_rise)
    else $error("write sync seen off a rising edge"); // [RQ10]
  AST_DIV_RANGE: assert property (tick |-> divcnt_ff == div - 6'h01
                                  || divcnt_ff >= div)
    else $error("output tick at wrong divider count"); // [RQ4]
  AST_FETCH: assert property (tick ##1 ctrl_ff.ena ##1 $stable(ctrl_ff)
                              |-> valid_ff && sample_ff == $past(mem_q))
    else $error("fetched sample not delivered"); // [RQ3]
  AST_BYPASS: assert property (!ctrl_ff.ena |-> !rd_rst)
    else $error("read reset while buffer bypassed"); // [RQ19]
  AST_OUTPUT_PHASE_STROBE: assert property (ctrl_ff.ena && sel_out[SEL_OUTPUT_PHASE_STROBE] && output_phase_strobe_ev
                             |=> rptr_ff == $past(offs_ff))
    else $error("phase strobe did not reset read pointer"); // [RQ14]
  AST_RECAP: assert property ($rose(pend_ff) |-> !recap_ev)
    else $error("recapture skipped synchroniser stages"); // [RQ23]
  AST_WRITE_WORD: assert property (wr_en_ff |-> phase_ff == 2'h0)
    else $error("write did not close a sample"); // [RQ2]

  COV_DUAL: cover property (ctrl_ff.ena && sel_out[SEL_OUTPUT_PHASE_STROBE] && output_phase_strobe_ev);
  COV_SINGLE: cover property (recap_ev && rd_rst);
  COV_WRAP: cover property (wr_en_ff && wr_addr_ff == 3'h7);
  COV_BYPASS: cover property (!ctrl_ff.ena && valid_ff);
endmodule

// ### test/dcef_src_model.sv
// data source model driving the double-data-rate input pins
`timescale 1ns/1ps
module dcef_src_model
  import dcef_pkg::*;
(
  input  wire logic  clk,        // system clock
  input  wire logic  rst_n,      // async reset, active low
  input  wire logic  wide,       // 1: word lanes, 0: byte lanes
  input  wire logic  frame_req,  // request one frame pulse
  input  wire logic  output_phase_strobe_req,   // request one strobe pulse
  output dcef_pins_t pins        // pin bundle to the buffer
);
  logic [4:0]  cnt_ff;
  logic [9:0]  edge_ff;
  logic [15:0] dat_ff;
  logic        frm_ff;
  logic        output_phase_strobe_ff;
  logic        fpend_ff;
  logic        opend_ff;

  // sample s is i={a0,s}, q={50,s}; idle upper lanes toggle in byte mode
  function automatic logic [15:0] word_for(input logic [9:0] e);
    logic [7:0] s;
    logic [7:0] b;
    s = wide ? e[8:1] : e[9:2];
    b = e[1] ? 8'h50 : 8'ha0;
    if (e[0]) b = s;
    if (wide) return {e[0] ? 8'h50 : 8'ha0, s};
    return {~b, b};
  endfunction

  // one counter makes both pin clocks, so the rates stay locked
  // sync mirrors frame so either write-side select sees the same pulse
  assign pins = {cnt_ff[4], dat_ff, frm_ff, frm_ff, cnt_ff[2], output_phase_strobe_ff};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= 5'h00;
      edge_ff  <= 10'h000;
      dat_ff   <= 16'h0000;
      frm_ff   <= 1'b0;
      output_phase_strobe_ff  <= 1'b0;
      fpend_ff <= 1'b0;
      opend_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
      if (frame_req) fpend_ff <= 1'b1;
      if (output_phase_strobe_req) opend_ff <= 1'b1;
      // data moves mid-phase, clear of both dclk edges
      if (cnt_ff == 5'h08 && fpend_ff) begin
        // frame only on request, far apart, ahead of a rising edge
        frm_ff   <= 1'b1;
        fpend_ff <= 1'b0;
        dat_ff   <= word_for(10'h000);
        edge_ff  <= 10'h001;
      end else if (cnt_ff == 5'h08 || cnt_ff == 5'h18) begin
        if (cnt_ff == 5'h08) frm_ff <= 1'b0;
        dat_ff  <= word_for(edge_ff);
        edge_ff <= edge_ff + 10'h001;
      end
      if (cnt_ff == 5'h00 && opend_ff) begin
        output_phase_strobe_ff  <= 1'b1;
        opend_ff <= 1'b0;
      end else if (cnt_ff == 5'h10) output_phase_strobe_ff <= 1'b0;
    end
  end
endmodule

// ### test/dcef_top_tb.sv
// self-checking bench for the elastic input buffer
`timescale 1ns/1ps
module dcef_top_tb;
  import dcef_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic         pready_ff;
  logic [31:0]  prdata_ff;
  logic         pslverr_ff;
  dcef_pins_t   pins;
  dcef_sample_t sample_ff;
  logic         valid_ff;
  logic         tick_ff;
  logic         wide;
  logic         frame_req;
  logic         output_phase_strobe_req;
  logic [31:0]  rd;
  logic         err;
  logic [2:0]   loc;
  int           n;
  int           bad_count;
  int           check_count;

  dcef_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_ff(pready_ff),
    .prdata_ff(prdata_ff), .pslverr_ff(pslverr_ff), .pins(pins),
    .sample_ff(sample_ff), .valid_ff(valid_ff), .tick_ff(tick_ff));

  dcef_src_model u_src (.clk(clk), .rst_n(rst_n), .wide(wide),
    .frame_req(frame_req), .output_phase_strobe_req(output_phase_strobe_req), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fail_wait();
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) fail_wait();
    end while (pready_ff !== 1'b1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return valid_ff;
      1: return tick_ff;
      2: return pins.output_phase_strobe;
      default: return ~pins.output_phase_strobe;
    endcase
  endfunction

  // counts edges until the chosen event is seen
  task automatic wait_for(input int w);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 400) fail_wait();
    end while (pick(w) !== 1'b1);
  endtask

  task automatic pulse(input logic fr);
    @(posedge clk);
    if (fr) frame_req <= 1'b1;
    else output_phase_strobe_req <= 1'b1;
    @(posedge clk);
    frame_req <= 1'b0;
    output_phase_strobe_req  <= 1'b0;
  endtask

  // locations hold stale or unwritten data until a full lap has passed
  task automatic settle();
    repeat (12) wait_for(0);
  endtask

  task automatic stream(input int k, input logic rel);
    repeat (k) begin
      wait_for(0);
      loc = sample_ff.i[2:0];
      chk({sample_ff.i[15:8], sample_ff.q}, {16'ha050, sample_ff.i[7:0]});
      if (rel) begin
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({29'h0, rd[6:4]}, {29'h0, loc + 3'h1});
      end
    end
  endtask

  task automatic first_loc(input logic [2:0] exp);
    wait_for(0);
    chk({29'h0, sample_ff.i[2:0]}, {29'h0, exp});
  endtask

  task automatic tick_gap(input int exp);
    wait_for(1);
    wait_for(1);
    chk(n, exp);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    wide = 1'b1;
    frame_req = 1'b0;
    output_phase_strobe_req = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(ADDR_STAT, 32'h0000_0140);
    rdchk(ADDR_CTRL, 32'h0000_0203);
    rdchk(ADDR_OFFS, 32'h0000_0004);
    rdchk(ADDR_SEL, 32'h0000_0042);
    rdchk(8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    pulse(1'b1);
    settle();
    tick_gap(32);
    stream(4, 1'b1);
    apb(1'b1, ADDR_OFFS, 32'h6);
    pulse(1'b0);
    wait_for(2);
    wait_for(3);
    first_loc(3'h6);
    stream(2, 1'b1);
    apb(1'b1, ADDR_SEL, 32'h11);
    pulse(1'b1);
    settle();
    stream(3, 1'b1);
    apb(1'b1, ADDR_SEL, 32'h88);
    wait_for(0);
    apb(1'b1, ADDR_CTRL, 32'h207);
    first_loc(3'h6);
    rdchk(ADDR_CTRL, 32'h0000_0203);
    apb(1'b1, ADDR_SEL, 32'h42);
    apb(1'b1, ADDR_CTRL, 32'h801);
    wide <= 1'b0;
    pulse(1'b1);
    settle();
    tick_gap(64);
    stream(4, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h800);
    rdchk(ADDR_CTRL, 32'h0000_0800);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({31'h0, rd[8]}, 32'h0);
    stream(3, 1'b0);
    print_verdict();
  end
endmodule
